// ### core/scs_top.sv
// speed command scaling, command source select, tuning-mode control
// assumes an AXI4-Lite master on SYS_CLK; selector pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "scs_regs.svh"
module scs_top #(
  parameter logic [15:0] RATED_SPEED = 16'h0bb8
) (
  // clock and reset
  input  wire logic                SYS_CLK,
  input  wire logic                RST,
  // axi4-lite slave
  input  wire logic [11:0]         AWADDR,
  input  wire logic                AWVALID,
  output logic                     AWREADY,
  input  wire logic [31:0]         WDATA,
  input  wire logic [3:0]          WSTRB,
  input  wire logic                WVALID,
  output logic                     WREADY,
  output logic [1:0]               BRESP,
  output logic                     BVALID,
  input  wire logic                BREADY,
  input  wire logic [11:0]         ARADDR,
  input  wire logic                ARVALID,
  output logic                     ARREADY,
  output logic [31:0]              RDATA,
  output logic [1:0]               RRESP,
  output logic                     RVALID,
  input  wire logic                RREADY,
  // host pins and digitised reference
  input  wire logic                SERVO_ON,
  input  wire logic                CMD_SELECT_LOW,
  input  wire logic                CMD_SELECT_HIGH,
  input  wire logic signed [15:0]  REF_MV,
  // speed loop side
  input  wire logic [15:0]         MEAS_INERTIA,
  input  wire scs_pkg::scs_gains_t MEAS_GAINS,
  output logic signed [15:0]       SPEED_CMD,
  output logic signed [15:0]       SPEED_LIMIT,
  output scs_pkg::scs_gains_t      GAINS,
  output logic [15:0]              INERTIA_RATIO,
  output logic                     MANUAL_ONLY,
  output logic                     AUTO_CONT,
  output logic                     INERTIA_FIXED,
  output logic                     PSEUDO_DERIVATIVE_FEEDFORWARD_SEL,
  output logic                     EASY_SEL
);
  import scs_pkg::*;

  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a == `SCS_FS_OFF) || (a == `SCS_TM_OFF) || (a == `SCS_STAT_OFF)
           || ((a >= `SCS_CTRL_OFF) && (a <= `SCS_INR_OFF) && (a[1:0] == 2'h0));
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction

  function automatic logic is_cont(input scs_tmode_t m);
    is_cont = (m == TM_PI_CONT) || (m == TM_PD_CONT);
  endfunction

  function automatic logic is_fix(input scs_tmode_t m);
    is_fix = (m == TM_PI_FIX) || (m == TM_PD_FIX);
  endfunction

  // reference clamped to full scale before the product
  function automatic logic [15:0] scale(input logic signed [15:0] v,
                                        input logic [15:0] f);
    logic signed [15:0] c;
    logic signed [32:0] p;
    c = v;
    if (v > `SCS_VFS_MV) c = `SCS_VFS_MV;
    else if (v < -`SCS_VFS_MV) c = -`SCS_VFS_MV;
    p = c * $signed({17'h0, f});
    p = p / 33'(`SCS_VFS_MV);
    scale = p[15:0];
  endfunction

  // two-stage synchroniser: bit0 servo on, bit1 low select, bit2 high select
  logic [2:0]  sync1;
  logic [2:0]  sync2;

  logic        aw_hold, next_aw_hold;
  logic        w_hold, next_w_hold;
  logic [11:0] waddr, next_waddr;
  logic [31:0] wdat, next_wdat;
  logic [3:0]  wstb, next_wstb;
  logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata, rd_val;
  logic        wr_go, wr_bad, tm_ok, wr_tm;
  scs_tmode_t  new_tm;

  logic [15:0] fs, next_fs;
  scs_tmode_t  tmode, next_tmode;
  scs_ctrl_t   ctrl, next_ctrl;
  logic [15:0] int_spd [3];
  logic [15:0] next_int_spd [3];
  scs_gains_t  ugain, next_ugain;
  logic [15:0] inr, next_inr;

  logic [1:0]  sel;
  logic        srv;
  scs_src_t    src;
  logic [15:0] val;
  logic [15:0] next_cmd, next_lim, next_inrto;
  scs_gains_t  next_gains;

  assign wr_go  = aw_hold && w_hold;
  assign tm_ok  = (wdat[15:0] <= `SCS_TM_MAX);
  // out-of-range tuning values are refused and leave the mode alone
  assign wr_bad = !addr_ok(waddr) || ((waddr == `SCS_TM_OFF) && !tm_ok);

  // bus handshake
  always_comb begin
    next_aw_hold = aw_hold;
    next_w_hold  = w_hold;
    next_waddr   = waddr;
    next_wdat    = wdat;
    next_wstb    = wstb;
    next_bvalid  = BVALID;
    next_bresp   = BRESP;
    next_rvalid  = RVALID;
    next_rdata   = RDATA;
    next_rresp   = RRESP;
    if (AWVALID && AWREADY) begin
      next_aw_hold = 1'b1;
      next_waddr   = AWADDR;
    end
    if (WVALID && WREADY) begin
      next_w_hold = 1'b1;
      next_wdat   = WDATA;
      next_wstb   = WSTRB;
    end
    if (BVALID && BREADY) next_bvalid = 1'b0;
    if (wr_go) begin
      next_aw_hold = 1'b0;
      next_w_hold  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = wr_bad ? `SCS_RESP_ERR : `SCS_RESP_OK;
    end
    if (RVALID && RREADY) next_rvalid = 1'b0;
    if (ARVALID && ARREADY) begin
      next_rvalid = 1'b1;
      next_rdata  = rd_val;
      next_rresp  = addr_ok(ARADDR) ? `SCS_RESP_OK : `SCS_RESP_ERR;
    end
    next_awready = !next_aw_hold && !next_bvalid;
    next_wready  = !next_w_hold && !next_bvalid;
    next_arready = !next_rvalid;
  end

  // read mux, unmapped words read zero
  always_comb begin
    rd_val = 32'h0;
    unique case (ARADDR)
      `SCS_FS_OFF:   rd_val[15:0] = fs;
      `SCS_TM_OFF:   rd_val[2:0] = tmode;
      `SCS_CTRL_OFF: rd_val[1:0] = ctrl;
      `SCS_INT0_OFF: rd_val[15:0] = int_spd[0];
      `SCS_INT1_OFF: rd_val[15:0] = int_spd[1];
      `SCS_INT2_OFF: rd_val[15:0] = int_spd[2];
      `SCS_GPOS_OFF: rd_val[15:0] = ugain.pos;
      `SCS_GKP_OFF:  rd_val[15:0] = ugain.kp;
      `SCS_GKI_OFF:  rd_val[15:0] = ugain.ki;
      `SCS_GEA_OFF:  rd_val[15:0] = ugain.ea;
      `SCS_GEB_OFF:  rd_val[15:0] = ugain.eb;
      `SCS_INR_OFF:  rd_val[15:0] = inr;
      `SCS_STAT_OFF: rd_val[7:0] = {src, tmode, sync2};
      default:       rd_val = 32'h0;
    endcase
  end

  // register file and tuning transitions
  always_comb begin
    next_fs      = fs;
    next_tmode   = tmode;
    next_ctrl    = ctrl;
    next_int_spd = int_spd;
    next_ugain   = ugain;
    next_inr     = inr;
    new_tm       = scs_tmode_t'(wdat[2:0]);
    wr_tm        = wr_go && (waddr == `SCS_TM_OFF) && tm_ok && wstb[0];
    if (wr_go && !wr_bad) begin
      unique case (waddr)
        `SCS_FS_OFF: begin
          next_fs = merge(fs, wdat, wstb);
          if (next_fs > `SCS_FS_MAX) next_fs = `SCS_FS_MAX;
        end
        `SCS_CTRL_OFF: if (wstb[0]) next_ctrl = scs_ctrl_t'(wdat[1:0]);
        `SCS_INT0_OFF: next_int_spd[0] = merge(int_spd[0], wdat, wstb);
        `SCS_INT1_OFF: next_int_spd[1] = merge(int_spd[1], wdat, wstb);
        `SCS_INT2_OFF: next_int_spd[2] = merge(int_spd[2], wdat, wstb);
        `SCS_GPOS_OFF: next_ugain.pos = merge(ugain.pos, wdat, wstb);
        `SCS_GKP_OFF:  next_ugain.kp = merge(ugain.kp, wdat, wstb);
        `SCS_GKI_OFF:  next_ugain.ki = merge(ugain.ki, wdat, wstb);
        `SCS_GEA_OFF:  next_ugain.ea = merge(ugain.ea, wdat, wstb);
        `SCS_GEB_OFF:  next_ugain.eb = merge(ugain.eb, wdat, wstb);
        `SCS_INR_OFF:  next_inr = merge(inr, wdat, wstb);
        default: ;
      endcase
    end
    if (wr_tm) begin
      next_tmode = new_tm;
      if (is_cont(tmode) && is_fix(new_tm)) next_inr = MEAS_INERTIA;
      // continuous modes never touch ugain, so going to manual restores manual gains; PD fixed to manual loads all measured gains, PI fixed only pos, kp, ki
      if (tmode == TM_PI_FIX && new_tm == TM_MANUAL) begin
        next_ugain.pos = MEAS_GAINS.pos;
        next_ugain.kp  = MEAS_GAINS.kp;
        next_ugain.ki  = MEAS_GAINS.ki;
      end
      if (tmode == TM_PD_FIX && new_tm == TM_MANUAL) next_ugain = MEAS_GAINS;
    end
  end

  // command source, scaling and loop-side outputs
  always_comb begin
    sel = sync2[2:1];
    srv = sync2[0];
    if (!srv) src = SRC_OFF;
    else if (sel != 2'h0) src = SRC_INT;
    else if (ctrl.zero) src = SRC_ZERO;
    else src = SRC_ANALOG;
    unique case (src)
      SRC_ANALOG: val = scale(REF_MV, fs);
      SRC_INT:    val = int_spd[2'(sel - 2'h1)];
      default:    val = 16'h0;
    endcase
    next_cmd   = ctrl.torque ? 16'h0 : val;
    next_lim   = ctrl.torque ? val : fs;
    next_gains = (tmode >= TM_PI_CONT) ? MEAS_GAINS : ugain;
    next_inrto = is_cont(tmode) ? MEAS_INERTIA : inr;
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      waddr <= 12'h0;
      wdat <= 32'h0;
      wstb <= 4'h0;
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= 2'h0;
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= 32'h0;
      RRESP <= 2'h0;
      fs <= RATED_SPEED;
      tmode <= TM_MANUAL;
      ctrl <= `SCS_CTRL_RST;
      int_spd <= '{default: 16'h0};
      ugain <= '0;
      inr <= 16'h0;
      SPEED_CMD <= 16'h0;
      SPEED_LIMIT <= 16'h0;
      GAINS <= '0;
      INERTIA_RATIO <= 16'h0;
      MANUAL_ONLY <= 1'b1;
      AUTO_CONT <= 1'b0;
      INERTIA_FIXED <= 1'b0;
      PSEUDO_DERIVATIVE_FEEDFORWARD_SEL <= 1'b0;
      EASY_SEL <= 1'b0;
    end else begin
      sync1 <= {CMD_SELECT_HIGH, CMD_SELECT_LOW, SERVO_ON};
      sync2 <= sync1;
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      waddr <= next_waddr;
      wdat <= next_wdat;
      wstb <= next_wstb;
      AWREADY <= next_awready;
      WREADY <= next_wready;
      BVALID <= next_bvalid;
      BRESP <= next_bresp;
      ARREADY <= next_arready;
      RVALID <= next_rvalid;
      RDATA <= next_rdata;
      RRESP <= next_rresp;
      fs <= next_fs;
      tmode <= next_tmode;
      ctrl <= next_ctrl;
      int_spd <= next_int_spd;
      ugain <= next_ugain;
      inr <= next_inr;
      SPEED_CMD <= next_cmd;
      SPEED_LIMIT <= next_lim;
      GAINS <= next_gains;
      INERTIA_RATIO <= next_inrto;
      MANUAL_ONLY <= (tmode == TM_MANUAL);
      AUTO_CONT <= is_cont(tmode);
      INERTIA_FIXED <= is_fix(tmode);
      PSEUDO_DERIVATIVE_FEEDFORWARD_SEL <= (tmode == TM_PD_CONT) || (tmode == TM_PD_FIX);
      EASY_SEL <= (tmode == TM_EASY);
    end
  end

  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  a_off_zero: assert property (!srv |=> SPEED_CMD == 16'h0)
    else $error("command not zero while drive off");
  a_zero_mode: assert property (srv && sel == 2'h0 && ctrl.zero |=>
    SPEED_CMD == 16'h0 && SPEED_LIMIT == ($past(ctrl.torque) ? 16'h0 : $past(fs)))
    else $error("zero-command mode leaked a value");
  a_full_scale: assert property (src == SRC_ANALOG && !ctrl.torque &&
    REF_MV == `SCS_VFS_MV |=> SPEED_CMD == $past(fs))
    else $error("ten volts did not give full-scale speed");
  a_saturate: assert property (src == SRC_ANALOG && !ctrl.torque &&
    REF_MV > `SCS_VFS_MV |=> SPEED_CMD == $past(fs))
    else $error("over-range reference not saturated");
  a_torque_lim: assert property (src == SRC_ANALOG && ctrl.torque &&
    REF_MV == -`SCS_VFS_MV |=> SPEED_CMD == 16'h0 && 16'(SPEED_LIMIT + $past(fs)) == 16'h0)
    else $error("torque-mode limit scaling wrong");
  a_int_select: assert property (srv && sel == 2'h2 && !ctrl.torque |=>
    SPEED_CMD == $past(int_spd[1]))
    else $error("internal speed not selected");
  a_mode_range: assert property (wr_go && waddr == `SCS_TM_OFF && !tm_ok |=>
    tmode == $past(tmode) && BVALID && BRESP == `SCS_RESP_ERR)
    else $error("out-of-range tuning mode accepted");
  a_manual_gains: assert property (tmode == TM_MANUAL |=> GAINS == $past(ugain))
    else $error("manual mode not using user gains");
  a_auto_gains: assert property (is_cont(tmode) |=> GAINS == $past(MEAS_GAINS) &&
    INERTIA_RATIO == $past(MEAS_INERTIA))
    else $error("continuous mode not tracking measured values");
  a_fix_inertia: assert property (wr_tm && is_cont(tmode) && is_fix(new_tm) |=>
    inr == $past(MEAS_INERTIA) ##1 INERTIA_RATIO == $past(inr))
    else $error("measured inertia not stored");
  a_back_manual: assert property (wr_tm && is_cont(tmode) && new_tm == TM_MANUAL |=>
    ugain == $past(ugain) ##1 GAINS == $past(ugain))
    else $error("manual gains not restored");
  a_fix_to_man: assert property (wr_tm && tmode == TM_PD_FIX && new_tm == TM_MANUAL |=>
    ugain == $past(MEAS_GAINS))
    else $error("measured gains not loaded from mode five");
  a_pi_to_man: assert property (wr_tm && tmode == TM_PI_FIX && new_tm == TM_MANUAL |=>
    ugain.ki == $past(MEAS_GAINS.ki) && ugain.ea == $past(ugain.ea))
    else $error("mode three gains loaded wrongly");

  c_cont_fix: cover property (wr_tm && is_cont(tmode) && is_fix(new_tm));
  c_fix_man: cover property (wr_tm && tmode == TM_PD_FIX && new_tm == TM_MANUAL);
  c_torque_an: cover property (src == SRC_ANALOG && ctrl.torque ##1 SPEED_LIMIT != 16'h0);

endmodule
`default_nettype wire

// ### core/scs_regs.svh
// register map, reset value, limits, response codes and scaling constants
// included by the scaling/tuning block; definitions only
`ifndef SCS_REGS_SVH
`define SCS_REGS_SVH

`define SCS_FS_OFF    12'h128
`define SCS_TM_OFF    12'h220
`define SCS_CTRL_OFF  12'h300
`define SCS_INT0_OFF  12'h304
`define SCS_INT1_OFF  12'h308
`define SCS_INT2_OFF  12'h30c
`define SCS_GPOS_OFF  12'h310
`define SCS_GKP_OFF   12'h314
`define SCS_GKI_OFF   12'h318
`define SCS_GEA_OFF   12'h31c
`define SCS_GEB_OFF   12'h320
`define SCS_INR_OFF   12'h324
`define SCS_STAT_OFF  12'h328

`define SCS_CTRL_RST  2'h0
`define SCS_TM_MAX    16'h0005
`define SCS_FS_MAX    16'h2710
`define SCS_VFS_MV    16'sh2710
`define SCS_RESP_OK   2'h0
`define SCS_RESP_ERR  2'h2

`endif

// ### core/scs_pkg.sv
// types shared by the speed scaling and tuning select block
// no assumptions beyond a SystemVerilog package scope
package scs_pkg;

  typedef enum logic [2:0] {
    TM_MANUAL,
    TM_EASY,
    TM_PI_CONT,
    TM_PI_FIX,
    TM_PD_CONT,
    TM_PD_FIX
  } scs_tmode_t;

  typedef enum logic [1:0] {
    SRC_OFF,
    SRC_ANALOG,
    SRC_ZERO,
    SRC_INT
  } scs_src_t;

  typedef struct packed {
    logic [15:0] pos;
    logic [15:0] kp;
    logic [15:0] ki;
    logic [15:0] ea;
    logic [15:0] eb;
  } scs_gains_t;

  typedef struct packed {
    logic zero;
    logic torque;
  } scs_ctrl_t;

endpackage

// ### bench/scs_host.sv
// host controller model: servo-on, two command selectors, reference in mV
// assumes the bench changes its requests just after a rising SYS_CLK edge
`timescale 1ns/1ps
`default_nettype none
module scs_host (
  // clock
  input  wire logic               SYS_CLK,
  // requests from the bench, {sel_high, sel_low, servo_on}
  input  wire logic [2:0]         req_pins,
  input  wire logic signed [15:0] req_mv,
  // pins toward the drive
  output logic                    servo_on,
  output logic                    sel_low,
  output logic                    sel_high,
  output logic signed [15:0]      ref_mv
);
  initial begin
    {sel_high, sel_low, servo_on} = 3'h0;
    ref_mv = 16'sh0;
  end
  // a real controller never drives past full scale, so neither do we
  always @(posedge SYS_CLK) begin
    {sel_high, sel_low, servo_on} <= req_pins;
    if (req_mv > 16'sh2710) ref_mv <= 16'sh2710;
    else if (req_mv < -16'sh2710) ref_mv <= -16'sh2710;
    else ref_mv <= req_mv;
  end
endmodule
`default_nettype wire

// ### bench/scs_top_tb.sv
// self-checking bench for the speed scaling and tuning select block
// assumes scs_pkg and scs_regs.svh on the include and compile path
`timescale 1ns/1ps
`default_nettype none
`include "scs_regs.svh"
module scs_top_tb;
  import scs_pkg::*;
  logic clk = 1'b0, rst = 1'b1;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'h3;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  logic servo_on, sel_lo, sel_hi;
  logic signed [15:0] ref_mv, cmd, lim, req_mv = 16'sh0;
  logic [2:0] req_pins = 3'h0;
  logic [15:0] meas_in = 16'h0055, ratio;
  scs_gains_t meas_g = {16'h0a1, 16'h0a2, 16'h0a3, 16'h0a4, 16'h0a5};
  scs_gains_t gains, user;
  logic man, cont, fixd, pseudo_derivative_feedforward, easy;
  int mismatches = 0, n_checks = 0;

  always #50 clk = ~clk;

  scs_host host (.SYS_CLK(clk), .req_pins(req_pins), .req_mv(req_mv), .servo_on(servo_on),
    .sel_low(sel_lo), .sel_high(sel_hi), .ref_mv(ref_mv));
  scs_top DUT (.SYS_CLK(clk), .RST(rst), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .SERVO_ON(servo_on), .CMD_SELECT_LOW(sel_lo), .CMD_SELECT_HIGH(sel_hi),
    .REF_MV(ref_mv), .MEAS_INERTIA(meas_in), .MEAS_GAINS(meas_g), .SPEED_CMD(cmd),
    .SPEED_LIMIT(lim), .GAINS(gains), .INERTIA_RATIO(ratio), .MANUAL_ONLY(man),
    .AUTO_CONT(cont), .INERTIA_FIXED(fixd), .PSEUDO_DERIVATIVE_FEEDFORWARD_SEL(pseudo_derivative_feedforward), .EASY_SEL(easy));

  task automatic end_of_test;
    if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ticks(input int k);
    repeat (k) @(posedge clk);
  endtask

  // a missing answer leaves rs at 3 and counts as a mismatch
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 50);
    rs = bvalid ? bresp : 2'h3;
    if (!bvalid) mismatches++;
    bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [11:0] a);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 50);
    rd = rdata;
    rs = rvalid ? rresp : 2'h3;
    if (!rvalid) mismatches++;
    rready <= 1'b0;
  endtask

  task automatic t_reset;
    rd_reg(`SCS_FS_OFF);
    chk(rd, 32'h0bb8);
    rd_reg(`SCS_TM_OFF);
    chk(rd, 32'h0);
    chk(man, 1'b1);
    rd_reg(12'h0f0);
    chk({rd, rs}, {32'h0, `SCS_RESP_ERR});
    // full scale above ten thousand is clamped, not refused
    wr(`SCS_FS_OFF, 32'd12000);
    chk(rs, `SCS_RESP_OK);
    rd_reg(`SCS_FS_OFF);
    chk(rd, 32'd10000);
  endtask

  task automatic t_scale;
    int fs[4] = '{7, 0, 3000, 3000};
    int mv[4] = '{-5000, 10000, -10000, 5000};
    for (int i = 0; i < 4; i++) begin
      wr(`SCS_FS_OFF, 32'(fs[i]));
      req_pins <= 3'b001;
      req_mv <= 16'(mv[i]);
      ticks(6);
      chk(cmd, 16'(mv[i] * fs[i] / 10000));
      chk(lim, 16'(fs[i]));
    end
    wr(`SCS_CTRL_OFF, 32'h1);
    ticks(6);
    chk({cmd, lim}, {16'h0, 16'sd1500});
    req_mv <= -16'sd10000;
    ticks(6);
    chk(lim, -16'sd3000);
    req_mv <= 16'sd5000;
    wr(`SCS_CTRL_OFF, 32'h2);
    ticks(6);
    chk({cmd, lim}, {16'h0, 16'sd3000});
    wr(`SCS_CTRL_OFF, 32'h0);
    ticks(6);
    chk(cmd, 16'sd1500);
  endtask

  task automatic t_select;
    logic signed [15:0] sp[3] = '{16'sd100, -16'sd200, 16'sd300};
    for (int i = 0; i < 3; i++) wr(`SCS_INT0_OFF + 12'(4 * i), 32'(sp[i]));
    for (int s = 1; s < 4; s++) begin
      req_pins <= {2'(s), 1'b1};
      ticks(6);
      chk(cmd, sp[s - 1]);
    end
    req_pins <= 3'b110;
    ticks(6);
    rd_reg(`SCS_STAT_OFF);
    chk(rd[7:0], 8'h06);
    chk(cmd, 16'h0);
  endtask

  // flags per mode: manual, continuous, fixed inertia, pseudo_derivative_feedforward, easy
  task automatic mode(input int m);
    logic [4:0] fl[6] = '{5'h10, 5'h01, 5'h08, 5'h04, 5'h0a, 5'h06};
    wr(`SCS_TM_OFF, 32'(m));
    ticks(2);
    chk({man, cont, fixd, pseudo_derivative_feedforward, easy}, fl[m]);
  endtask

  task automatic t_tune;
    for (int i = 0; i < 5; i++) wr(`SCS_GPOS_OFF + 12'(4 * i), 32'(i + 1));
    user = {16'h1, 16'h2, 16'h3, 16'h4, 16'h5};
    wr(`SCS_TM_OFF, 32'h6);
    chk(rs, `SCS_RESP_ERR);
    mode(1);
    chk(gains, user);
    mode(2);
    chk({gains, ratio}, {meas_g, meas_in});
    mode(3);
    meas_in <= 16'h0066;
    ticks(3);
    chk(ratio, 16'h0055);
    mode(0);
    user = {meas_g[79:32], user[31:0]};
    chk(gains, user);
    mode(4);
    meas_g <= {16'h0b1, 16'h0b2, 16'h0b3, 16'h0b4, 16'h0b5};
    mode(0);
    chk(gains, user);
    wr(`SCS_INR_OFF, 32'h77);
    chk(rs, `SCS_RESP_OK);
    mode(5);
    chk(ratio, 16'h0077);
    mode(0);
    chk(gains, meas_g);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_scale;
    t_select;
    t_tune;
    end_of_test;
  end

  // whole run is a few hundred cycles; this is over a hundred times that
  initial begin
    #3000000;
    mismatches++;
    end_of_test;
  end
endmodule
`default_nettype wire
